// file: hdl/facr_top.v
/*
  Address, buffer-select and command registers of a flash device with an
  internal buffer RAM, reached over APB.  Decoded operations are handed
  to a flash core outside this block, which reports completion and each
  finished sector transfer.
  Registers are 16 bits in the low half of each APB word; unmapped
  word indices answer with pslverr.  A status word holds the ready
  indication and the live buffer sector walk, a second word a sticky
  done bit.
  Assumes: APB master on pclk; flash core on the same clock; core_done
  and sector_step are one-cycle pulses from that core.
*/
`timescale 1ns/1ns
`default_nettype none
`include "facr_map.vh"

// What this block does
// RQ1: Copy-back block index, 9 bits, upper bits zero, resets to zero.
// RQ2: Copy-back page index 6 bits and sector index 2 bits, reset zero.
// RQ3: Start page index and start sector index for load, program, copy-back.
// RQ4: Sector count sets sectors moved; 0, the reset value, means four.
// RQ5: Low two buffer address bits step and wrap per sector, upper kept.
// RQ6: Bit 3 boot or data RAM, bit 2 data half, bits 1:0 the sector.
// RQ7: Host writes a command only right after clearing ready to busy.
// RQ8: Any completed operation returns the indication to ready.
// RQ9: While busy only the two resets pass; some operations accept nothing.
// RQ10: Code 0000h loads main-data sectors from array into buffer.
// RQ11: Code 0013h loads spare-area sectors into buffer.
// RQ12: Code 0080h programs main and spare; 001Ah programs spare only.
// RQ13: Code 001Bh copy-back programs to the held destination address.
// RQ14: Codes 0023h, 002Ah, 002Ch unlock, lock, lock-tight the block.
// RQ15: Code 00F0h resets only the flash core and its operation.
// RQ16: Code 00F3h resets all registers and core, like a warm reset; the done bit is set instead of cleared.
// RQ17: Host fills read-only spare part with FF for program commands.
// RQ18: Registers F101h and F104h to F106h are reserved with no function.
// RQ19: Source block index, 9 bits, used by load, program and erase.
// RQ20: Remaining codes decode to erase, suspend, resume, OTP; others ignored.
// RQ21: A command starts with register values current at its write.
module facr_top
#(
  parameter BLOCK_W  = `FACR_BLOCK_W,
  parameter PAGE_W   = `FACR_PAGE_W,
  parameter SECTOR_W = `FACR_SECTOR_W
)
(
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [17:0]          paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output reg                  pready,
  output reg                  pslverr,
  input  wire                 core_done,
  input  wire                 sector_step,
  output reg                  op_start,
  output reg  [`FACR_OP_W-1:0] op_code,
  output reg  [BLOCK_W-1:0]   op_src_block,
  output reg  [BLOCK_W-1:0]   op_cb_block,
  output reg  [PAGE_W-1:0]    op_cb_page,
  output reg  [SECTOR_W-1:0]  op_cb_sector,
  output reg  [PAGE_W-1:0]    op_page,
  output reg  [SECTOR_W-1:0]  op_sector,
  output reg  [2:0]           op_sector_total,
  output reg                  buf_boot_sel,
  output reg                  buf_data_half,
  output reg  [1:0]           buf_sector,
  output reg                  core_reset,
  output reg                  ready_flag
);

  localparam BSA_W = `FACR_BSA_W;
  localparam BSC_W = `FACR_BSC_W;

  // Busy-acceptance classes of a running operation
  localparam ACC_ALL   = 2'b00;
  localparam ACC_RESET = 2'b01;
  localparam ACC_NONE  = 2'b10;

  // Sector totals handed to the core
  localparam [2:0] SECT_NONE = 3'h0;
  localparam [2:0] SECT_ONE  = 3'h1;
  localparam [2:0] SECT_MAX  = 3'h4;

  reg [BLOCK_W-1:0]  src_block_q;
  reg [BLOCK_W-1:0]  cb_block_q;
  reg [PAGE_W-1:0]   cb_page_q;
  reg [SECTOR_W-1:0] cb_sector_q;
  reg [PAGE_W-1:0]   st_page_q;
  reg [SECTOR_W-1:0] st_sector_q;
  reg [BSA_W-1:0]    bsa_q;
  reg [BSC_W-1:0]    bsc_q;
  reg [15:0]         cmd_q;
  reg [1:0]          accept_q;
  reg [2:0]          sectors_left_q;
  reg [BSA_W-1:0]    bsa_walk_q;
  reg                hot_reset_q;
  reg                done_seen_q;

  // One wait state: a transfer is taken on its first access edge
  wire        access = psel & penable;
  wire        wr     = access & pwrite & ~pready;
  wire        rd     = access & ~pwrite & ~pready;
  wire [15:0] index  = paddr[17:2];
  wire [15:0] wdata  = pwdata[15:0];

  reg         mapped;
  reg  [15:0] rd_word;

  // Read mux: reserved words read zero, unknown indices raise an error
  always @*
  begin
    mapped  = 1'b1;
    rd_word = 16'h0000;
    case (index)
      `FACR_IDX_SRC_BLOCK:   rd_word = {{(16-BLOCK_W){1'b0}}, src_block_q};
      `FACR_IDX_START_TWO:   rd_word = 16'h0000; // RQ18
      `FACR_IDX_CB_BLOCK:    rd_word = {{(16-BLOCK_W){1'b0}}, cb_block_q};
      `FACR_IDX_CB_PAGESEC:
        rd_word = {{(16-PAGE_W-SECTOR_W){1'b0}}, cb_page_q, cb_sector_q};
      `FACR_IDX_START_FIVE:  rd_word = 16'h0000; // RQ18
      `FACR_IDX_START_SIX:   rd_word = 16'h0000; // RQ18
      `FACR_IDX_START_SEVEN: rd_word = 16'h0000; // RQ18
      `FACR_IDX_START_PGSEC:
        rd_word = {{(16-PAGE_W-SECTOR_W){1'b0}}, st_page_q, st_sector_q};
      `FACR_IDX_BUF_SELECT:
        rd_word = {4'h0, bsa_q, 6'h00, bsc_q};
      `FACR_IDX_COMMAND:     rd_word = cmd_q;
      `FACR_IDX_STATUS:
        rd_word = {11'h000, bsa_walk_q, ready_flag};
      `FACR_IDX_DONE:        rd_word = {15'h0000, done_seen_q};
      default:               mapped = 1'b0;
    endcase
  end

  // Command decode to an operation and its busy-acceptance class
  reg [`FACR_OP_W-1:0] dec_op;
  reg [1:0]            dec_acc;

  always @*
  begin
    dec_op  = `FACR_OP_NONE;
    dec_acc = ACC_RESET;
    case (wdata)
      `FACR_CMD_LOAD_MAIN:    dec_op = `FACR_OP_LOAD_MAIN;    // RQ10
      `FACR_CMD_LOAD_SPARE:   dec_op = `FACR_OP_LOAD_SPARE;   // RQ11
      `FACR_CMD_PROG_MAIN:    dec_op = `FACR_OP_PROG_MAIN;    // RQ12
      `FACR_CMD_PROG_SPARE:   dec_op = `FACR_OP_PROG_SPARE;   // RQ12
      `FACR_CMD_COPY_BACK:    dec_op = `FACR_OP_COPY_BACK;    // RQ13
      `FACR_CMD_UNLOCK:
      begin
        dec_op  = `FACR_OP_UNLOCK; // RQ14
        dec_acc = ACC_NONE;
      end
      `FACR_CMD_LOCK:
      begin
        dec_op  = `FACR_OP_LOCK; // RQ14
        dec_acc = ACC_NONE;
      end
      `FACR_CMD_LOCK_TIGHT:
      begin
        dec_op  = `FACR_OP_LOCK_TIGHT; // RQ14
        dec_acc = ACC_NONE;
      end
      `FACR_CMD_ERASE_VRFY:   dec_op = `FACR_OP_ERASE_VRFY;   // RQ20
      `FACR_CMD_BLK_ERASE:    dec_op = `FACR_OP_BLK_ERASE;    // RQ20
      `FACR_CMD_MULTI_ERASE:  dec_op = `FACR_OP_MULTI_ERASE;  // RQ20
      `FACR_CMD_ERASE_SUSP:
      begin
        dec_op  = `FACR_OP_ERASE_SUSP; // RQ20
        dec_acc = ACC_NONE;
      end
      `FACR_CMD_ERASE_RESUME: dec_op = `FACR_OP_ERASE_RESUME; // RQ20
      `FACR_CMD_OTP_ACCESS:   dec_op = `FACR_OP_OTP_ACCESS;   // RQ20
      `FACR_CMD_CORE_RESET:
      begin
        dec_op  = `FACR_OP_CORE_RESET; // RQ15
        dec_acc = ACC_NONE;
      end
      default:                dec_op = `FACR_OP_NONE;         // RQ20
    endcase
  end

  wire is_reset_cmd = (wdata == `FACR_CMD_CORE_RESET) |
                      (wdata == `FACR_CMD_HOT_RESET);
  wire cmd_wr   = wr & (index == `FACR_IDX_COMMAND);
  // Clearing ready from the host does not block a command; a running
  // operation does, and lets through only the resets that it allows
  wire op_idle  = (accept_q == ACC_ALL);
  wire cmd_ok   = op_idle | (is_reset_cmd & (accept_q == ACC_RESET)); // RQ9
  wire cmd_take = cmd_wr & cmd_ok;
  wire hot_take = cmd_take & (wdata == `FACR_CMD_HOT_RESET);             // RQ16
  wire run_take = cmd_take & ~hot_take & (dec_op != `FACR_OP_NONE);
  wire multi_op = (dec_op == `FACR_OP_LOAD_MAIN) |
                  (dec_op == `FACR_OP_LOAD_SPARE) |
                  (dec_op == `FACR_OP_PROG_MAIN) |
                  (dec_op == `FACR_OP_PROG_SPARE) |
                  (dec_op == `FACR_OP_COPY_BACK);
  wire [2:0] bsc_total = (bsc_q == 2'b00) ? SECT_MAX : {1'b0, bsc_q}; // RQ4
  // Software busy request: writing zero to the ready bit (RQ7 on host side)
  wire rdy_clr = wr & (index == `FACR_IDX_STATUS) & ~wdata[0];
  wire rdy_set = wr & (index == `FACR_IDX_STATUS) & wdata[0];
  wire done_clr = wr & (index == `FACR_IDX_DONE) & wdata[0];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_block_q     <= {BLOCK_W{1'b0}};
      cb_block_q      <= {BLOCK_W{1'b0}};
      cb_page_q       <= {PAGE_W{1'b0}};
      cb_sector_q     <= {SECTOR_W{1'b0}};
      st_page_q       <= {PAGE_W{1'b0}};
      st_sector_q     <= {SECTOR_W{1'b0}};
      bsa_q           <= {BSA_W{1'b0}};
      bsc_q           <= {BSC_W{1'b0}};
      cmd_q           <= `FACR_REG_RESET;
      accept_q        <= ACC_ALL;
      sectors_left_q  <= 3'd0;
      bsa_walk_q      <= {BSA_W{1'b0}};
      hot_reset_q     <= 1'b0;
      done_seen_q     <= 1'b0;
      ready_flag      <= 1'b1;
      prdata          <= 32'h00000000;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      op_start        <= 1'b0;
      op_code         <= `FACR_OP_NONE;
      op_src_block    <= {BLOCK_W{1'b0}};
      op_cb_block     <= {BLOCK_W{1'b0}};
      op_cb_page      <= {PAGE_W{1'b0}};
      op_cb_sector    <= {SECTOR_W{1'b0}};
      op_page         <= {PAGE_W{1'b0}};
      op_sector       <= {SECTOR_W{1'b0}};
      op_sector_total <= 3'd0;
      buf_boot_sel    <= 1'b0;
      buf_data_half   <= 1'b0;
      buf_sector      <= 2'b00;
      core_reset      <= 1'b0;
    end
    else if (hot_reset_q)
    begin
      // Hot reset: every register back to default except the done bit, which is set; core reset too
      src_block_q     <= {BLOCK_W{1'b0}};  // RQ16
      cb_block_q      <= {BLOCK_W{1'b0}};
      cb_page_q       <= {PAGE_W{1'b0}};
      cb_sector_q     <= {SECTOR_W{1'b0}};
      st_page_q       <= {PAGE_W{1'b0}};
      st_sector_q     <= {SECTOR_W{1'b0}};
      bsa_q           <= {BSA_W{1'b0}};
      bsc_q           <= {BSC_W{1'b0}};
      cmd_q           <= `FACR_REG_RESET;
      accept_q        <= ACC_ALL;
      sectors_left_q  <= 3'd0;
      bsa_walk_q      <= {BSA_W{1'b0}};
      hot_reset_q     <= 1'b0;
      done_seen_q     <= 1'b1;
      ready_flag      <= 1'b1;             // RQ8
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      op_start        <= 1'b0;
      op_code         <= `FACR_OP_NONE;
      // Launched operands and buffer select return to defaults as well
      prdata          <= 32'h00000000;
      op_src_block    <= {BLOCK_W{1'b0}};
      op_cb_block     <= {BLOCK_W{1'b0}};
      op_cb_page      <= {PAGE_W{1'b0}};
      op_cb_sector    <= {SECTOR_W{1'b0}};
      op_page         <= {PAGE_W{1'b0}};
      op_sector       <= {SECTOR_W{1'b0}};
      op_sector_total <= SECT_NONE;
      buf_boot_sel    <= 1'b0;
      buf_data_half   <= 1'b0;
      buf_sector      <= 2'b00;
      core_reset      <= 1'b1;
    end
    else
    begin
      // Bus answer one cycle after the access phase opens
      pready   <= access & ~pready;
      pslverr  <= access & ~pready & ~mapped;
      op_start <= run_take;
      core_reset <= run_take & (dec_op == `FACR_OP_CORE_RESET); // RQ15
      // Hot reset takes effect on the next edge, after this answer
      hot_reset_q <= hot_take;

      // Read data stands until the next read or a hot reset
      if (rd)
        prdata <= {16'h0000, rd_word};

      // Reserved, status and unknown words keep their state here
      if (wr)
      begin
        case (index)
          `FACR_IDX_SRC_BLOCK:  src_block_q <= wdata[BLOCK_W-1:0]; // RQ19
          `FACR_IDX_CB_BLOCK:   cb_block_q  <= wdata[BLOCK_W-1:0]; // RQ1
          `FACR_IDX_CB_PAGESEC:
          begin
            cb_page_q   <= wdata[PAGE_W+SECTOR_W-1:SECTOR_W]; // RQ2
            cb_sector_q <= wdata[SECTOR_W-1:0];               // RQ2
          end
          `FACR_IDX_START_PGSEC:
          begin
            st_page_q   <= wdata[PAGE_W+SECTOR_W-1:SECTOR_W]; // RQ3
            st_sector_q <= wdata[SECTOR_W-1:0];               // RQ3
          end
          `FACR_IDX_BUF_SELECT:
          begin
            bsa_q <= wdata[`FACR_BSA_LSB+BSA_W-1:`FACR_BSA_LSB];
            bsc_q <= wdata[BSC_W-1:0];                        // RQ4
          end
          default:
          begin
            cmd_q <= cmd_q;
          end
        endcase
      end

      // Unknown codes are stored but launch nothing
      if (cmd_take)
        cmd_q <= wdata;

      if (run_take)
      begin
        // Operands frozen from the registers at the command write
        op_code         <= dec_op;        // RQ21
        op_src_block    <= src_block_q;   // RQ21
        op_cb_block     <= cb_block_q;    // RQ13
        op_cb_page      <= cb_page_q;     // RQ13
        op_cb_sector    <= cb_sector_q;   // RQ13
        op_page         <= st_page_q;     // RQ3
        op_sector       <= st_sector_q;   // RQ3
        op_sector_total <= multi_op ? bsc_total : SECT_NONE; // RQ4
        sectors_left_q  <= multi_op ? bsc_total : SECT_NONE;
        bsa_walk_q      <= bsa_q;
        buf_boot_sel    <= bsa_q[3];      // RQ6
        buf_data_half   <= bsa_q[2];      // RQ6
        buf_sector      <= bsa_q[1:0];    // RQ6
        accept_q        <= dec_acc;       // RQ9
        ready_flag      <= 1'b0;
      end
      else if (sector_step && sectors_left_q != SECT_NONE)
      begin
        // Sector walk wraps inside the selected RAM half
        bsa_walk_q     <= {bsa_walk_q[3:2], bsa_walk_q[1:0] + 2'b01}; // RQ5
        buf_sector     <= bsa_walk_q[1:0] + 2'b01;                   // RQ5
        sectors_left_q <= sectors_left_q - SECT_ONE;
      end

      // Completion wins over a software clear in the same cycle
      if (core_done && !run_take)
      begin
        ready_flag <= 1'b1; // RQ8
        accept_q   <= ACC_ALL;
      end
      else if (rdy_clr && !run_take)
        ready_flag <= 1'b0;
      else if (rdy_set && !run_take)
        ready_flag <= 1'b1;

      // Sticky done: a set wins over a clear
      if (core_done || hot_take)
        done_seen_q <= 1'b1;
      else if (done_clr)
        done_seen_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: hdl/facr_map.vh
/*
  Register map, field layout, reset values and command codes of the
  flash address and command register block.
  Assumes: included by the block's design file only.
*/
`ifndef FACR_MAP_VH
`define FACR_MAP_VH

// Printed offsets are word indices; byte address is four times the index
`define FACR_IDX_SRC_BLOCK    16'hf100
`define FACR_IDX_START_TWO    16'hf101
`define FACR_IDX_CB_BLOCK     16'hf102
`define FACR_IDX_CB_PAGESEC   16'hf103
`define FACR_IDX_START_FIVE   16'hf104
`define FACR_IDX_START_SIX    16'hf105
`define FACR_IDX_START_SEVEN  16'hf106
`define FACR_IDX_START_PGSEC  16'hf107
`define FACR_IDX_BUF_SELECT   16'hf200
`define FACR_IDX_COMMAND      16'hf220
`define FACR_IDX_STATUS       16'hf240
`define FACR_IDX_DONE         16'hf241

`define FACR_BLOCK_W          9
`define FACR_PAGE_W           6
`define FACR_SECTOR_W         2
`define FACR_BSA_W            4
`define FACR_BSC_W            2
`define FACR_BSA_LSB          8
`define FACR_REG_RESET        16'h0000

`define FACR_CMD_LOAD_MAIN    16'h0000
`define FACR_CMD_LOAD_SPARE   16'h0013
`define FACR_CMD_PROG_MAIN    16'h0080
`define FACR_CMD_PROG_SPARE   16'h001a
`define FACR_CMD_COPY_BACK    16'h001b
`define FACR_CMD_UNLOCK       16'h0023
`define FACR_CMD_LOCK         16'h002a
`define FACR_CMD_LOCK_TIGHT   16'h002c
`define FACR_CMD_ERASE_VRFY   16'h0071
`define FACR_CMD_BLK_ERASE    16'h0094
`define FACR_CMD_MULTI_ERASE  16'h0095
`define FACR_CMD_ERASE_SUSP   16'h00b0
`define FACR_CMD_ERASE_RESUME 16'h0030
`define FACR_CMD_CORE_RESET   16'h00f0
`define FACR_CMD_HOT_RESET    16'h00f3
`define FACR_CMD_OTP_ACCESS   16'h0065

`define FACR_OP_W             4
`define FACR_OP_NONE          4'h0
`define FACR_OP_LOAD_MAIN     4'h1
`define FACR_OP_LOAD_SPARE    4'h2
`define FACR_OP_PROG_MAIN     4'h3
`define FACR_OP_PROG_SPARE    4'h4
`define FACR_OP_COPY_BACK     4'h5
`define FACR_OP_UNLOCK        4'h6
`define FACR_OP_LOCK          4'h7
`define FACR_OP_LOCK_TIGHT    4'h8
`define FACR_OP_ERASE_VRFY    4'h9
`define FACR_OP_BLK_ERASE     4'ha
`define FACR_OP_MULTI_ERASE   4'hb
`define FACR_OP_ERASE_SUSP    4'hc
`define FACR_OP_ERASE_RESUME  4'hd
`define FACR_OP_CORE_RESET    4'he
`define FACR_OP_OTP_ACCESS    4'hf

`endif

// file: test/facr_properties.sv
/* Concurrent checks on the ports of facr_top.
   Assumes: bound to facr_top; single pclk domain, presetn active low. */
`timescale 1ns/1ns
`default_nettype none
module facr_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        core_done,
  input wire logic        sector_step,
  input wire logic        op_start,
  input wire logic [3:0]  op_code,
  input wire logic [2:0]  op_sector_total,
  input wire logic        buf_boot_sel,
  input wire logic [1:0]  buf_sector,
  input wire logic        core_reset,
  input wire logic        ready_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable && !pready;
  wire logic mapped = paddr[17:5] == 13'h1e20 || paddr[17:2] == 16'hf200 ||
                      paddr[17:2] == 16'hf220 || paddr[17:3] == 15'h7920;

  one_wait_a: assert property (acc |=> pready ##1 !pready)
    else $error("access phase not answered after one wait state");
  start_busy_a: assert property (op_start |-> !ready_flag)
    else $error("operation launched while ready");
  done_ready_a: assert property (core_done && !(psel && pwrite) |=>
    ready_flag)
    else $error("completion did not restore ready");
  sector_wrap_a: assert property (sector_step && !psel |=>
    buf_sector == 2'($past(buf_sector) + 2'd1) && $stable(buf_boot_sel))
    else $error("buffer sector did not advance with wrap");
  boot_hold_a: assert property (!op_start && !core_reset |->
    $stable(buf_boot_sel))
    else $error("buffer RAM select moved outside a launch");
  total_a: assert property (op_start |-> op_sector_total <= 3'd4 &&
    ((op_code >= 4'h1 && op_code <= 4'h5) == (op_sector_total != 3'd0)))
    else $error("sector total wrong for operation");
  core_rst_a: assert property (op_start && op_code == 4'he |->
    core_reset)
    else $error("core reset not pulsed");
  map_err_a: assert property (acc |=> pslverr == !$past(mapped))
    else $error("error response does not match address map");

  cover property (op_start && op_code == 4'h5);
  cover property (sector_step && buf_sector == 2'd3);
  cover property (pslverr);
endmodule
bind facr_top facr_properties chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .core_done(core_done),
  .sector_step(sector_step), .op_start(op_start), .op_code(op_code),
  .op_sector_total(op_sector_total), .buf_boot_sel(buf_boot_sel),
  .buf_sector(buf_sector), .core_reset(core_reset),
  .ready_flag(ready_flag));
`default_nettype wire

// file: test/facr_core_model.sv
/* Flash core stand-in: answers each launch with sector steps and a
   completion pulse, fast or slow.  Assumes: same clock as facr_top. */
`timescale 1ns/1ns
`default_nettype none
module facr_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       op_start,
  input  wire logic       core_reset,
  input  wire logic       slow,
  input  wire logic [2:0] op_sector_total,
  output var  logic       core_done,
  output var  logic       sector_step
);
  int         cnt_q;
  logic [2:0] left_q;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_q <= 0;
      left_q <= 3'd0;
      core_done <= 1'b0;
      sector_step <= 1'b0;
    end
    else
    begin
      core_done <= cnt_q == 1 && !op_start && !core_reset;
      sector_step <= 1'b0;
      if (op_start)
      begin
        cnt_q <= slow ? 200 : 12;
        left_q <= op_sector_total;
      end
      else if (core_reset)
        cnt_q <= 0;
      else if (cnt_q > 0)
      begin
        cnt_q <= cnt_q - 1;
        // Steps on odd counts so pulses never touch
        if (cnt_q < 11 && cnt_q[0] && left_q != 3'd0)
        begin
          sector_step <= 1'b1;
          left_q <= left_q - 3'd1;
        end
      end
    end
endmodule
`default_nettype wire

// file: test/test_flash_addr_cmd_registers.sv
/* Self-checking bench for facr_top over APB with a flash core model.
   Assumes: facr_top, facr_core_model and the checker compiled first. */
`timescale 1ns/1ns
`default_nettype none
module test_flash_addr_cmd_registers;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, w;
  logic        pready, pslverr, core_done, sector_step, op_start, core_reset;
  logic        ready_flag, buf_boot_sel, buf_data_half, slow = 0, er, st;
  logic [3:0]  op_code;
  logic [8:0]  op_src_block, op_cb_block;
  logic [5:0]  op_cb_page, op_page;
  logic [1:0]  op_cb_sector, op_sector, buf_sector;
  logic [2:0]  op_sector_total;
  logic [15:0] v [5];
  int          err_count = 0, checks = 0, seed = 32'h141d, n;
  logic [15:0] ix [5] = '{16'hf100, 16'hf102, 16'hf103, 16'hf107, 16'hf200};
  logic [15:0] mk [5] = '{16'h01ff, 16'h01ff, 16'h00ff, 16'h00ff, 16'h0f03};
  logic [15:0] cmd [16] = '{16'h1234, 16'h0000, 16'h0013, 16'h0080,
    16'h001a, 16'h001b, 16'h0023, 16'h002a, 16'h002c, 16'h0071, 16'h0094,
    16'h0095, 16'h00b0, 16'h0030, 16'h00f0, 16'h0065};

  always #4 pclk = ~pclk;

  facr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_done(core_done), .sector_step(sector_step), .op_start(op_start),
    .op_code(op_code), .op_src_block(op_src_block),
    .op_cb_block(op_cb_block), .op_cb_page(op_cb_page),
    .op_cb_sector(op_cb_sector), .op_page(op_page), .op_sector(op_sector),
    .op_sector_total(op_sector_total), .buf_boot_sel(buf_boot_sel),
    .buf_data_half(buf_data_half), .buf_sector(buf_sector),
    .core_reset(core_reset), .ready_flag(ready_flag));
  facr_core_model core_u (.pclk(pclk), .presetn(presetn),
    .op_start(op_start), .core_reset(core_reset), .slow(slow),
    .op_sector_total(op_sector_total), .core_done(core_done),
    .sector_step(sector_step));

  function logic [2:0] tot(input int op, input logic [1:0] c);
    tot = (op > 0 && op < 6) ? (c == 2'd0 ? 3'd4 : {1'b0, c}) : 3'd0;
  endfunction

  task chk(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int k;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {a, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
        @(posedge pclk);
        k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (k == 20)
        err_count++;
      rd = prdata;
      er = pslverr;
      st = op_start;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task rd_chk(input logic [15:0] a, input logic [15:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, {16'h0, e});
  endtask

  task wait_rdy;
    n = 0;
    while (ready_flag !== 1'b1 && n < 500)
    begin
      @(posedge pclk);
      n++;
    end
    chk(ready_flag, 1'b1);
  endtask

  task summarize;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #400000;
    err_count++;
    summarize;
  end

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd_chk(16'hf100 + i, 16'h0);
    rd_chk(16'hf200, 16'h0);
    rd_chk(16'hf220, 16'h0);
    rd_chk(16'hf240, 16'h1);
    for (int i = 1; i < 7; i++)
      if (i != 2 && i != 3)
      begin
        apb(1'b1, 16'hf100 + i, 32'hffff);
        rd_chk(16'hf100 + i, 16'h0);
      end
    apb(1'b0, 16'hf300, 32'h0);
    chk({er, rd}, 33'h100000000);
    for (int i = 0; i < 16; i++)
    begin
      for (int k = 0; k < 5; k++)
      begin
        w = $random(seed);
        v[k] = w[15:0] & mk[k];
        apb(1'b1, ix[k], {16'h0, w[15:0]});
        rd_chk(ix[k], v[k]);
      end
      apb(1'b1, 16'hf240, 32'h0);
      apb(1'b1, 16'hf220, {16'h0, cmd[i]});
      chk(st, i != 0);
      if (i == 0)
      begin
        rd_chk(16'hf220, 16'h1234);
        apb(1'b1, 16'hf240, 32'h1);
      end
      else
      begin
        chk(op_code, i);
        chk({op_src_block, op_cb_block, op_cb_page, op_cb_sector, op_page,
          op_sector}, {v[0][8:0], v[1][8:0], v[2][7:0], v[3][7:0]});
        chk(op_sector_total, tot(i, v[4][1:0]));
        if (i < 6)
          chk({buf_boot_sel, buf_data_half, buf_sector}, v[4][11:8]);
      end
      wait_rdy;
      if (i > 0 && i < 6)
        chk(buf_sector, 2'(v[4][9:8] + tot(i, v[4][1:0])));
    end
    slow <= 1'b1;
    apb(1'b1, 16'hf240, 32'h0);
    apb(1'b1, 16'hf220, 32'h0094);
    apb(1'b1, 16'hf220, 32'h0080);
    chk(st, 1'b0);
    rd_chk(16'hf220, 16'h0094);
    slow <= 1'b0;
    apb(1'b1, 16'hf220, 32'h00f0);
    chk({st, op_code}, 5'h1e);
    wait_rdy;
    slow <= 1'b1;
    apb(1'b1, 16'hf240, 32'h0);
    apb(1'b1, 16'hf220, 32'h002a);
    apb(1'b1, 16'hf220, 32'h00f0);
    chk(st, 1'b0);
    slow <= 1'b0;
    wait_rdy;
    apb(1'b1, 16'hf240, 32'h0);
    apb(1'b1, 16'hf220, 32'h00f3);
    chk(st, 1'b0);
    for (int k = 0; k < 5; k++)
      rd_chk(ix[k], 16'h0);
    rd_chk(16'hf220, 16'h0);
    chk(ready_flag, 1'b1);
    chk({buf_boot_sel, buf_data_half, buf_sector, op_sector_total}, 7'h0);
    summarize;
  end
endmodule
`default_nettype wire
